// File: bench/acp_host.sv
`timescale 1ns/1ps
// Host model: single APB transfers, request held until pready is seen
module acp_host (
  input  wire logic        clk_sys,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb
);
  logic last_err;  // Error flag taken at the access edge
  // Idle bus from time zero
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  end
  // Raw set means the reserved feature bits go out as given
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d, input bit raw);
    logic [7:0] wd;
    wd = d;
    if (!raw && a == acp_pkg::ADDR_FEATURE) begin
      wd[5:3] = 3'h0;  // Reserved bits written as zero
    end
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {1'b1, 1'b0, wr, a, 24'h0, wd, 4'hf};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : acp_host

// File: bench/adc_channel_power_feature_regs_tb_top.sv
`timescale 1ns/1ps
// Eight- and four-channel banks share one host
module adc_channel_power_feature_regs_tb_top;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, prdata4;
  logic [3:0]  pstrb;
  logic [7:0]  chan_powerdown;
  logic [1:0]  chain_position_id;
  logic [2:0]  output_frame_format, active_chan;
  logic        manual_channel_mode, data_invalid, manual_chan_down, data_invalid4;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cyc = 0;
  acp_host u_host (.clk_sys(clk_sys), .pready(pready), .pslverr(pslverr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
  acp_regs #(.FOUR_CHAN(1'b0)) i_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chan_powerdown(chan_powerdown), .chain_position_id(chain_position_id),
    .output_frame_format(output_frame_format), .manual_channel_mode(manual_channel_mode),
    .active_chan(active_chan), .data_invalid(data_invalid), .manual_chan_down(manual_chan_down));
  acp_regs #(.FOUR_CHAN(1'b1)) i_dut4 (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata4), .pready(),
    .pslverr(), .chan_powerdown(), .chain_position_id(), .output_frame_format(), .manual_channel_mode(),
    .active_chan(), .data_invalid(data_invalid4), .manual_chan_down());
  always #5 clk_sys = ~clk_sys;
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Transfer, then one edge so registered results land
  task automatic xf(input logic w, input logic [11:0] a, input logic [7:0] d, input bit raw);
    u_host.xfer(w, a, d, raw);
    @(posedge clk_sys);
    #1;
  endtask : xf
  // Next powered channel above c, wrapping
  function automatic logic [2:0] nxt(input logic [2:0] c, input logic [7:0] m);
    for (int i = 0; i < 8; i++) begin
      c = c + 3'h1;
      if (!m[c]) return c;
    end
    return 3'h0;
  endfunction : nxt
  // Reset values, mask writes, invalid flag and the small variant
  task automatic t_pwrdn();
    xf(1'b0, acp_pkg::ADDR_PWRDN, 8'h00, 1'b0);
    chk("pwrdn read", prdata[7:0], acp_pkg::RST_PWRDN);
    chk("pwrdn out", chan_powerdown, 8'h00);
    chk("chain out", 8'(chain_position_id), 8'h00);
    chk("format out", 8'(output_frame_format), 8'h00);
    xf(1'b1, acp_pkg::ADDR_PWRDN, 8'h5a, 1'b0);
    chk("pwrdn out", chan_powerdown, 8'h5a);
    chk("invalid", 8'(data_invalid), 8'h00);
    xf(1'b1, acp_pkg::ADDR_PWRDN, 8'hff, 1'b0);
    chk("invalid all", 8'(data_invalid), 8'h01);
    xf(1'b0, acp_pkg::ADDR_PWRDN, 8'h00, 1'b0);
    chk("pwrdn read", prdata[7:0], 8'hff);
    chk("four read", prdata4[7:0], 8'hff);
    chk("four invalid", 8'(data_invalid4), 8'h01);
    xf(1'b1, acp_pkg::ADDR_PWRDN, 8'h02, 1'b0);
    xf(1'b0, acp_pkg::ADDR_PWRDN, 8'h00, 1'b0);
    chk("four upper", prdata4[7:0], 8'hf2);
    $display("power-down test done");
  endtask : t_pwrdn
  // Scan over channels 0, 2 and 4 only, then one manual channel
  task automatic t_scan();
    logic [2:0] c;
    int         w;
    xf(1'b1, acp_pkg::ADDR_PWRDN, 8'hea, 1'b0);
    repeat (4) begin
      c = active_chan;
      w = 0;
      while (active_chan === c && w < 300) begin
        @(posedge clk_sys);
        #1;
        w++;
      end
      chk("scan chan", 8'(active_chan), 8'(nxt(c, 8'hea)));
    end
    // Manual channel 2 stays powered, only 3 goes down
    xf(1'b1, acp_pkg::ADDR_PWRDN, 8'h08, 1'b0);
    xf(1'b1, acp_pkg::ADDR_SCAN_CTRL, 8'h21, 1'b0);
    chk("manual chan", 8'(active_chan), 8'h02);
    chk("manual down", 8'(manual_chan_down), 8'h00);
    chk("manual mode", 8'(manual_channel_mode), 8'h01);
    xf(1'b0, acp_pkg::ADDR_SCAN_CTRL, 8'h00, 1'b0);
    chk("ctrl read", prdata[7:0] & 8'h8f, 8'h01);
    $display("scan test done");
  endtask : t_scan
  // Feature fields, soft reset and an unmapped address
  task automatic t_feature();
    logic [2:0] c;
    // Raw writes set reserved bits, every chain id and format
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      xf(1'b1, acp_pkg::ADDR_FEATURE, {c[1:0], 3'h7, c}, 1'b1);
      chk("chain", 8'(chain_position_id), 8'(c[1:0]));
      chk("format", 8'(output_frame_format), 8'(c));
      xf(1'b0, acp_pkg::ADDR_FEATURE, 8'h00, 1'b0);
      chk("feature read", prdata[7:0], {c[1:0], 3'h0, c});
    end
    // Soft reset restores defaults; unmapped read is refused
    xf(1'b1, acp_pkg::ADDR_SCAN_CTRL, 8'h02, 1'b0);
    chk("soft pwrdn", chan_powerdown, 8'h00);
    chk("soft chain", 8'({chain_position_id, output_frame_format}), 8'h00);
    xf(1'b0, 12'h100, 8'h00, 1'b0);
    chk("unmapped err", 8'(u_host.last_err), 8'h01);
    chk("unmapped data", prdata[7:0], 8'h00);
    $display("feature test done");
  endtask : t_feature
  // Reset in mid-run returns every register to its default
  task automatic t_reset();
    xf(1'b1, acp_pkg::ADDR_PWRDN, 8'h5a, 1'b0);
    xf(1'b1, acp_pkg::ADDR_FEATURE, 8'h83, 1'b0);
    xf(1'b1, acp_pkg::ADDR_SCAN_CTRL, 8'h01, 1'b0);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("reset pwrdn", chan_powerdown, acp_pkg::RST_PWRDN);
    chk("reset feature", 8'({chain_position_id, 3'h0, output_frame_format}), acp_pkg::RST_FEATURE);
    chk("reset mode", 8'(manual_channel_mode), 8'h00);
    xf(1'b0, acp_pkg::ADDR_FEATURE, 8'h00, 1'b0);
    chk("reset read", prdata[7:0], acp_pkg::RST_FEATURE);
    $display("reset test done");
  endtask : t_reset
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_pwrdn();
    t_scan();
    t_feature();
    t_reset();
    wrap_up();
  end
endmodule : adc_channel_power_feature_regs_tb_top

// File: hw/acp_pkg.sv
package acp_pkg;
  // Register word offsets (byte addresses are four times these)
  localparam logic [7:0]  IDX_PWRDN      = 8'h02;  // Channel power-down mask
  localparam logic [7:0]  IDX_FEATURE    = 8'h03;  // Feature select
  localparam logic [7:0]  IDX_SCAN_CTRL  = 8'h10;  // Scan control and status
  localparam logic [11:0] ADDR_PWRDN     = 12'h008;
  localparam logic [11:0] ADDR_FEATURE   = 12'h00c;
  localparam logic [11:0] ADDR_SCAN_CTRL = 12'h040;
  // Reset values, and the all-channels-down pattern
  localparam logic [7:0]  RST_PWRDN      = 8'h00;
  localparam logic [7:0]  RST_FEATURE    = 8'h00;
  localparam logic [7:0]  ALL_DOWN       = 8'hff;
  // Feature select field layout
  localparam int          CHAIN_ID_LSB   = 6;
  localparam int          FMT_LSB        = 0;
  localparam logic [7:0]  FEATURE_WMASK  = 8'hc7;  // Bits 5..3 read zero
  // Scan control field layout
  localparam int          SC_MANUAL_BIT  = 0;
  localparam int          SC_SOFTRST_BIT = 1;
  localparam int          SC_CHAN_LSB    = 4;
  // Full channel count, and present-channel mask for the small variant
  localparam int          NUM_CHAN       = 8;
  localparam logic [7:0]  MASK_4CH       = 8'h0f;
  // Conversion pacing: 500 kHz aggregate at 100 MHz
  localparam int          CONV_NS        = 2000;
  localparam int          CLK_NS         = 10;
  localparam int          CONV_CYC       = CONV_NS / CLK_NS;
  localparam logic [7:0]  CONV_CYC_W     = 8'(CONV_CYC - 1);
endpackage : acp_pkg

// File: hw/acp_regs.sv
`timescale 1ns/1ps
// Overview of operation
// R01: Power-down mask resets to zero.
// R02: Set bit powers down channel, drops from scan.
// R03: All bits set: all down, data invalid.
// R04: Host avoids powering down manual channel.
// R05: Small variant: upper bits ignore writes, read ones.
// R06: Bits 7-6 hold chain position, reset zero.
// R07: Bits 5-3 read zero; host writes zero.
// R08: Bits 2-0 select frame format, reset zero.
// R09: Auto scan ascends, one channel per conversion.
// R10: Power-on and soft reset restore defaults.
module acp_regs #(
  parameter bit FOUR_CHAN = 1'b0        // Build the four-channel variant
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [7:0]  chan_powerdown,     // Front-end power-down per channel
  output logic      [1:0]  chain_position_id,  // Daisy-chain position
  output logic      [2:0]  output_frame_format,// Serial frame format
  output logic             manual_channel_mode,// Manual channel selection active
  output logic      [2:0]  active_chan,        // Channel being converted
  output logic             data_invalid,       // Converter output not valid
  output logic             manual_chan_down    // Manual channel is powered down
);
  // All state in one struct
  typedef struct packed {
    logic [7:0] pwrdn;
    logic [7:0] feature;
    logic       manual;
    logic [2:0] man_chan;
    logic [7:0] conv_cnt;
    logic [31:0] rdata;
  } acp_regs_state_t;

  acp_regs_state_t st, next_st;
  logic            wr_en;       // Write accepted this edge
  logic            rd_en;       // Read accepted this edge
  logic            soft_rst;    // Software reset request
  logic            conv_tick;   // One pulse per conversion
  logic [7:0]      present;     // Channels that exist in this variant
  logic [7:0]      eligible;    // Powered channels for the scan
  logic [2:0]      scan_chan;   // Sequencer output
  logic [7:0]      rd_val;      // Register value for a read
  logic            addr_ok;     // Address hits a register

  // Zero wait state slave; an access completes in its first access cycle
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign present = FOUR_CHAN ? acp_pkg::MASK_4CH : 8'hff;
  assign soft_rst = wr_en && pstrb[0] && (paddr == acp_pkg::ADDR_SCAN_CTRL)
                    && pwdata[acp_pkg::SC_SOFTRST_BIT];
  assign conv_tick = (st.conv_cnt == acp_pkg::CONV_CYC_W);

  // Address decode; unmapped addresses return an error
  always_comb begin
    addr_ok = 1'b1;
    case (paddr)
      acp_pkg::ADDR_PWRDN:     rd_val = st.pwrdn | ~present;                  // see R05
      acp_pkg::ADDR_FEATURE:   rd_val = st.feature & acp_pkg::FEATURE_WMASK;  // see R07
      acp_pkg::ADDR_SCAN_CTRL: rd_val = {1'b0, scan_chan, 3'h0, st.manual};
      default: begin
        rd_val  = 8'h00;
        addr_ok = 1'b0;
      end
    endcase
  end
  assign pslverr = psel && penable && !addr_ok;

  // Next-state logic for registers, pacing and read data
  always_comb begin
    next_st = st;
    next_st.conv_cnt = conv_tick ? 8'h00 : 8'(st.conv_cnt + 8'h01);
    if (rd_en) begin
      next_st.rdata = {24'h0, rd_val};
    end
    if (wr_en && pstrb[0]) begin
      case (paddr)
        acp_pkg::ADDR_PWRDN: begin
          // Absent channels keep their stored zero
          next_st.pwrdn = pwdata[7:0] & present;                           // see R05
        end
        acp_pkg::ADDR_FEATURE: begin
          // Reserved bits never stored, so they read back zero
          next_st.feature = pwdata[7:0] & acp_pkg::FEATURE_WMASK;          // see R07
        end
        acp_pkg::ADDR_SCAN_CTRL: begin
          next_st.manual   = pwdata[acp_pkg::SC_MANUAL_BIT];
          next_st.man_chan = pwdata[acp_pkg::SC_CHAN_LSB +: 3];
        end
        default: begin
          next_st = next_st;
        end
      endcase
    end
    if (soft_rst) begin
      next_st.pwrdn   = acp_pkg::RST_PWRDN;                                // see R10
      next_st.feature = acp_pkg::RST_FEATURE;                              // see R10
      next_st.manual  = 1'b0;
      next_st.man_chan = 3'h0;
    end
  end

  // State register; reset gives all defaults
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st <= '0;                                                            // see R01
    end else begin
      st <= next_st;
    end
  end

  // Powered, present channels form the scan set
  assign eligible = ~st.pwrdn & present;                                   // see R02

  acp_scan u_scan (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .conv_tick (conv_tick),
    .eligible  (eligible),
    .cur_chan  (scan_chan)
  );

  // Outputs
  assign prdata              = st.rdata;
  assign chan_powerdown      = st.pwrdn;                                   // see R02
  assign chain_position_id   = st.feature[acp_pkg::CHAIN_ID_LSB +: 2];     // see R06
  assign output_frame_format = st.feature[acp_pkg::FMT_LSB +: 3];          // see R08
  assign manual_channel_mode = st.manual;
  assign active_chan         = st.manual ? st.man_chan : scan_chan;
  // Every present channel down means nothing is converted
  assign data_invalid        = ((st.pwrdn | ~present) == acp_pkg::ALL_DOWN)
                               || manual_chan_down;                        // see R03
  // Flag for host misuse; output is garbage but the block does not block it
  assign manual_chan_down    = st.manual && st.pwrdn[st.man_chan];         // see R04

  // Checks below watch only what this block drives; the bus side is
  // taken as legal, so a broken host shows up as a wrong register here.
  // Reserved feature bits are never stored, which is why a host that
  // writes ones there is tolerated rather than flagged.

  // Mask must leave reset at zero, every front-end powered
  a_pwrdn_reset: assert property (@(posedge clk_sys)  // see R01
    $fell(rst) |-> chan_powerdown == acp_pkg::RST_PWRDN)
    else $error("mask not zero after reset");

  // Chain position leaves reset at device zero
  a_chain_reset: assert property (@(posedge clk_sys)  // see R06
    $fell(rst) |-> chain_position_id == 2'h0)
    else $error("chain id not zero after reset");

  // Frame format leaves reset at code zero
  a_fmt_reset: assert property (@(posedge clk_sys)  // see R08
    $fell(rst) |-> output_frame_format == 3'h0)
    else $error("format not zero after reset");

  // Auto mode out of reset; a stale manual channel would
  // otherwise steer the first conversions somewhere unexpected
  a_mode_reset: assert property (@(posedge clk_sys)  // see R10
    $fell(rst) |-> !manual_channel_mode)
    else $error("manual mode set after reset");

  // A strobed mask write lands on the next edge; a soft reset
  // on the same edge wins, so it is left out here
  a_pwrdn_write: assert property (@(posedge clk_sys) disable iff (rst)  // see R02
    wr_en && pstrb[0] && paddr == acp_pkg::ADDR_PWRDN && !soft_rst
    |=> chan_powerdown == ($past(pwdata[7:0]) & present))
    else $error("mask write lost");

  // Mask moves only on its own strobed write or a soft reset;
  // a write with the low strobe off must leave it alone
  a_pwrdn_hold: assert property (@(posedge clk_sys) disable iff (rst)  // see R02
    !(wr_en && pstrb[0] && paddr == acp_pkg::ADDR_PWRDN) && !soft_rst
    |=> $stable(chan_powerdown))
    else $error("mask changed without a write");

  // Mask read returns the stored mask, absent channels as ones
  a_pwrdn_read: assert property (@(posedge clk_sys) disable iff (rst)  // see R05
    rd_en && paddr == acp_pkg::ADDR_PWRDN
    |=> prdata == {24'h0, $past(chan_powerdown) | ~present})
    else $error("mask read wrong");

  // Absent channels never hold a one, so the stored mask stays
  // honest even though reads show those bits as ones
  a_small_keep: assert property (@(posedge clk_sys) disable iff (rst)  // see R05
    FOUR_CHAN |-> (chan_powerdown & ~acp_pkg::MASK_4CH) == 8'h00)
    else $error("absent channel bit stored");

  // Absent channels read back as ones in the small variant
  a_small_ones: assert property (@(posedge clk_sys) disable iff (rst)  // see R05
    FOUR_CHAN && rd_en && paddr == acp_pkg::ADDR_PWRDN
    |=> prdata[7:4] == 4'hf)
    else $error("absent bits not ones");

  // All present channels down must flag the converter output;
  // absent channels count as down in the small variant
  a_all_invalid: assert property (@(posedge clk_sys) disable iff (rst)  // see R03
    (chan_powerdown | ~present) == acp_pkg::ALL_DOWN |-> data_invalid)
    else $error("all down not invalid");

  // Output stays good while a present channel is up in auto mode
  a_valid_data: assert property (@(posedge clk_sys) disable iff (rst)  // see R03
    !manual_channel_mode && (chan_powerdown | ~present) != acp_pkg::ALL_DOWN |-> !data_invalid)
    else $error("data flagged invalid with channels up");

  // Host misuse: manual channel powered down. The block does not
  // refuse the write, it only reports it
  a_manual_flag: assert property (@(posedge clk_sys) disable iff (rst)  // see R04
    manual_channel_mode && chan_powerdown[active_chan] |-> manual_chan_down)
    else $error("manual channel down not seen");

  // Misuse by the host spoils the converter output
  a_manual_down: assert property (@(posedge clk_sys) disable iff (rst)  // see R04
    manual_chan_down |-> data_invalid)
    else $error("manual down not flagged");

  // Feature register: two live fields around a three-bit gap. The
  // gap is masked on write, so reads and outputs can never see it

  // A feature write sets the chain position on the next edge
  a_chain_id: assert property (@(posedge clk_sys) disable iff (rst)  // see R06
    wr_en && pstrb[0] && paddr == acp_pkg::ADDR_FEATURE
    |=> chain_position_id == $past(pwdata[7:6]))
    else $error("chain id wrong");

  // A feature write sets the frame format on the next edge
  a_frame_fmt: assert property (@(posedge clk_sys) disable iff (rst)  // see R08
    wr_en && pstrb[0] && paddr == acp_pkg::ADDR_FEATURE
    |=> output_frame_format == $past(pwdata[2:0]))
    else $error("format wrong");

  // Feature fields move only on their own write or a soft reset
  a_feature_hold: assert property (@(posedge clk_sys) disable iff (rst)  // see R06
    !(wr_en && pstrb[0] && paddr == acp_pkg::ADDR_FEATURE) && !soft_rst
    |=> $stable(chain_position_id) && $stable(output_frame_format))
    else $error("feature changed without a write");

  // Gap bits always read as zero
  a_rsvd_zero: assert property (@(posedge clk_sys) disable iff (rst)  // see R07
    rd_en && paddr == acp_pkg::ADDR_FEATURE |=> prdata[5:3] == 3'h0)
    else $error("reserved nonzero");

  // Feature read packs both fields around the zero gap
  a_feature_read: assert property (@(posedge clk_sys) disable iff (rst)  // see R08
    rd_en && paddr == acp_pkg::ADDR_FEATURE
    |=> prdata == {24'h0, $past(chain_position_id), 3'h0, $past(output_frame_format)})
    else $error("feature read wrong");

  // Sequencer: it moves once per conversion tick, to the next
  // eligible channel above, and parks on channel 0 with none left.
  // A mask write between ticks is honoured at the next tick only,
  // so the conversion in flight finishes on its old channel.

  // Scan channel moves only on a conversion tick
  a_scan_hold: assert property (@(posedge clk_sys) disable iff (rst)  // see R09
    !conv_tick |=> $stable(scan_chan))
    else $error("scan moved between conversions");

  // With another channel eligible, each conversion moves on;
  // a lone eligible channel is converted again and again
  a_scan_moves: assert property (@(posedge clk_sys) disable iff (rst)  // see R09
    conv_tick && (eligible & ~(8'h01 << scan_chan)) != 8'h00 |=> $changed(scan_chan))
    else $error("scan stuck on one channel");

  // Next channel up is taken when it is eligible, so the order
  // can only ascend, wrapping from the top to the lowest eligible channel
  a_scan_ascend: assert property (@(posedge clk_sys) disable iff (rst)  // see R09
    conv_tick && eligible[3'(scan_chan + 3'h1)] |=> scan_chan == $past(3'(scan_chan + 3'h1)))
    else $error("scan skipped an eligible channel");

  // No eligible channel: conversions fall back to channel 0
  a_scan_none: assert property (@(posedge clk_sys) disable iff (rst)  // see R09
    conv_tick && eligible == 8'h00 |=> scan_chan == 3'h0)
    else $error("scan left channel zero with none eligible");

  // Conversion ticks are single pulses, well apart; only the
  // first few cycles are checked to keep the property cheap
  a_conv_gap: assert property (@(posedge clk_sys) disable iff (rst)  // see R09
    conv_tick |=> (!conv_tick) [*8])
    else $error("conversion ticks too close");

  // Soft reset clears the mask and both feature fields, even
  // when the same write also carries other control bits
  a_soft_reset: assert property (@(posedge clk_sys) disable iff (rst)  // see R10
    soft_rst |=> chan_powerdown == acp_pkg::RST_PWRDN && chain_position_id == 2'h0
    && output_frame_format == 3'h0)
    else $error("soft reset incomplete");

  // Soft reset also drops back to auto mode
  a_soft_mode: assert property (@(posedge clk_sys) disable iff (rst)  // see R10
    soft_rst |=> !manual_channel_mode)
    else $error("soft reset left manual mode");

  // Main scenarios worth seeing at least once
  // Converter output invalid: every channel down or manual channel down
  c_all_down: cover property (@(posedge clk_sys) disable iff (rst) data_invalid);
  // Software reset issued
  c_soft_rst: cover property (@(posedge clk_sys) disable iff (rst) soft_rst);
  // Unmapped address refused
  c_bad_addr: cover property (@(posedge clk_sys) disable iff (rst) pslverr);
  // A non-default frame format
  c_fmt_set:  cover property (@(posedge clk_sys) disable iff (rst) output_frame_format == 3'h3);
  // Manual channel selection in use
  c_manual_on: cover property (@(posedge clk_sys) disable iff (rst) manual_channel_mode);
endmodule : acp_regs

// File: hw/acp_scan.sv
`timescale 1ns/1ps
// Automatic scan sequencer: picks next eligible channel in ascending order
module acp_scan (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       conv_tick,    // One pulse per conversion
  input  wire logic [7:0] eligible,     // Channels allowed in sequence
  output logic      [2:0] cur_chan      // Channel being converted
);
  // Whole module state
  typedef struct packed {
    logic [2:0] chan;
  } acp_scan_state_t;

  acp_scan_state_t st, next_st;
  logic [2:0]      pick;    // Next candidate channel
  logic            found;   // Candidate found

  // Search upward from current channel, wrapping; channel 0 if none
  always_comb begin
    logic [2:0] c;
    c = 3'h0;
    pick = 3'h0;
    found = 1'b0;
    for (int i = 1; i <= 8; i++) begin
      c = 3'(st.chan + 3'(i));
      if (!found && eligible[c]) begin
        pick = c;
        found = 1'b1;
      end
    end
    next_st = st;
    if (conv_tick) begin
      next_st.chan = found ? pick : 3'h0;  // see R09
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cur_chan = st.chan;

  // Advance lands on an eligible channel whenever one exists; a mask
  // write on the same edge as the tick is only seen at the next tick
  a_scan_eligible: assert property (@(posedge clk_sys) disable iff (rst)  // see R09
    conv_tick && (eligible != 8'h00) ##1 $stable(eligible) |-> eligible[cur_chan])
    else $error("scan moved to ineligible channel");
endmodule : acp_scan
